// >>> trace_unit_pkg.sv
// Constants for the sequential break and trace capture unit
package trace_unit_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] WIN_LO_OFS   = 8'h04;
   localparam logic [7:0] WIN_HI_OFS   = 8'h08;
   localparam logic [7:0] QUAL_OFS     = 8'h0C;
   localparam logic [7:0] PREREQ_OFS   = 8'h10;
   localparam logic [7:0] ACTION_OFS   = 8'h14;
   localparam logic [7:0] STATUS_OFS   = 8'h18;
   localparam logic [7:0] BUF_SEL_OFS  = 8'h1C;
   localparam logic [7:0] BUF_SRC_OFS  = 8'h20;
   localparam logic [7:0] BUF_DST_OFS  = 8'h24;
   localparam logic [7:0] BUF_INFO_OFS = 8'h28;
   // Control bit positions
   localparam int CTRL_TRACE_EN = 0;
   localparam int CTRL_EXT_EN   = 1;
   localparam int CTRL_REALTIME = 2;
   localparam int CTRL_STOP     = 3;
   localparam int CTRL_WIDE     = 4;
   localparam int CTRL_BRANCH   = 5;
   localparam int CTRL_RANGE    = 6;
   localparam int CTRL_SOFT     = 7;
   localparam int CTRL_WIDTH    = 8;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;
   // Range qualifier bit positions
   localparam int QUAL_RD       = 0;
   localparam int QUAL_WR       = 1;
   localparam int QUAL_ASID_EN  = 2;
   localparam int QUAL_CYC_EN   = 3;
   localparam int QUAL_CYC_LSB  = 4;
   localparam int QUAL_ASID_LSB = 8;
   // Prerequisite and action field encodings (4 bits per channel)
   localparam int               FIELD_W   = 4;
   localparam logic [1:0]       PRE_NONE  = 2'h0;
   localparam logic [1:0]       PRE_CHAN  = 2'h1;
   localparam logic [1:0]       PRE_MATCH = 2'h2;
   localparam logic [1:0]       ACT_SET   = 2'h1;
   localparam logic [1:0]       ACT_CLEAR = 2'h2;
   // Trace record kinds
   typedef enum logic [1:0] {REC_BRANCH, REC_RANGE, REC_SOFT} rec_kind_type;
   // Trace buffer and port geometry
   localparam int          BUF_DEPTH  = 8;
   localparam int          PORT_W     = 4;
   localparam int          FRAME_W    = 72;
   localparam int          FRAME_NIBS = FRAME_W / PORT_W;
   localparam logic [31:0] RESET_VEC  = 32'hA000_0000;
   localparam logic [31:0] INSN_STEP  = 32'h0000_0002;
endpackage : trace_unit_pkg

// >>> seq_break_trace.sv
// Sequential break sequencer and trace capture unit
`timescale 1ns/10ps
// Summary of operation
// - Channel with channel prerequisite counts only after that prerequisite was met.
// - Channel with match-flag prerequisite counts only while match flag is set.
// - A channel serving as prerequisite never breaks; it arms dependents and still applies its action.
// - Each channel's action sets or clears the shared match flag when met.
// - A break returns the match flag to cleared.
// - Internal buffer keeps eight records: the latest eight in continue mode, the first eight in stop mode.
// - Branch record holds source, destination, branch type and bus master type.
// - Range trace records in-window accesses, qualified by direction, ASID, cycle.
// - Software trace captures instruction PC and one selected general register.
// - Realtime mode never stalls the CPU; records arriving while busy drop.
// - Non-realtime mode stalls the CPU until pending output completes.
// - Continue mode overwrites the oldest record when full.
// - Stop mode halts acquisition when full; program keeps running.
// - External trace uses a 4-bit data port collected by the probe.
// - The 8-bit port mode is not supported; its control bit reads zero.
// - External trace enabled forces shared pins to trace function.
// - Zero-displacement conditional branches and reset jump are not recorded.
// - Completion-type exception records the address after the faulting one.
module seq_break_trace #(
   parameter int NCHAN = 4
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // Register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   // Event channels and break
   input  wire logic [NCHAN-1:0]     chan_hit,
   input  wire logic                 cpu_halted,
   output logic                      break_req,
   // Branch events
   input  wire logic                 br_valid,
   input  wire logic [31:0]          br_src,
   input  wire logic [31:0]          br_dst,
   input  wire logic [1:0]           br_type,
   input  wire logic [1:0]           br_master,
   input  wire logic                 br_cond_zero,
   input  wire logic                 br_exc_done,
   // Bus accesses
   input  wire logic                 acc_valid,
   input  wire logic [31:0]          acc_addr,
   input  wire logic                 acc_write,
   input  wire logic [7:0]           acc_asid,
   input  wire logic [1:0]           acc_cycle,
   // Software trace instruction
   input  wire logic                 sw_valid,
   input  wire logic [31:0]          sw_pc,
   input  wire logic [31:0]          sw_reg,
   // CPU stall and trace port
   output logic                      cpu_stall,
   output logic [trace_unit_pkg::PORT_W-1:0] trace_data_pins,
   output logic                      trace_valid,
   output logic                      trace_port_select
);
   localparam int PTR_W = $clog2(trace_unit_pkg::BUF_DEPTH);

   logic [trace_unit_pkg::CTRL_WIDTH-1:0] ctrl_reg;
   logic [31:0]                win_lo_reg;
   logic [31:0]                win_hi_reg;
   logic [15:0]                qual_reg;
   logic [NCHAN*4-1:0]         prereq_reg;
   logic [NCHAN*4-1:0]         action_reg;
   logic [PTR_W-1:0]           sel_reg;
   logic                       match_reg;
   logic [NCHAN-1:0]           done_reg;
   logic [NCHAN-1:0]           counts;
   logic [NCHAN-1:0]           is_prereq;
   logic [31:0]                src_mem [trace_unit_pkg::BUF_DEPTH];
   logic [31:0]                dst_mem [trace_unit_pkg::BUF_DEPTH];
   logic [5:0]                 info_mem [trace_unit_pkg::BUF_DEPTH];
   logic [PTR_W-1:0]           wr_ptr_reg;
   logic [PTR_W:0]             count_reg;
   logic                       stopped_reg;
   logic [7:0]                 lost_reg;
   logic [trace_unit_pkg::FRAME_W-1:0] frame_reg;
   logic [4:0]                 nib_reg;
   logic                       busy;
   logic                       br_ok;
   logic                       rng_ok;
   logic                       rec_valid;
   logic [31:0]                rec_src;
   logic [31:0]                rec_dst;
   logic [5:0]                 rec_info;
   logic                       ext_on;
   logic                       take_ext;
   logic                       take_int;
   logic                       full;

   // Kind field of a per-channel setting (prerequisite or action)
   function automatic logic [1:0] chan_kind(input logic [NCHAN*4-1:0] v, input int i);
      chan_kind = v[i*trace_unit_pkg::FIELD_W +: 2];
   endfunction : chan_kind

   // Channel index field of a per-channel prerequisite setting
   function automatic logic [1:0] chan_src(input logic [NCHAN*4-1:0] v, input int i);
      chan_src = v[i*trace_unit_pkg::FIELD_W + 2 +: 2];
   endfunction : chan_src

   // Register writes; the wide port bit is never stored
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_reg   <= trace_unit_pkg::CTRL_RESET;
         win_lo_reg <= 32'h0000_0000;
         win_hi_reg <= 32'h0000_0000;
         qual_reg   <= 16'h0000;
         prereq_reg <= '0;
         action_reg <= '0;
         sel_reg    <= '0;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            trace_unit_pkg::CTRL_OFS:
            begin
               ctrl_reg <= reg_wdata[trace_unit_pkg::CTRL_WIDTH-1:0];
               ctrl_reg[trace_unit_pkg::CTRL_WIDE] <= 1'b0;
            end
            trace_unit_pkg::WIN_LO_OFS:  win_lo_reg <= reg_wdata;
            trace_unit_pkg::WIN_HI_OFS:  win_hi_reg <= reg_wdata;
            trace_unit_pkg::QUAL_OFS:    qual_reg   <= reg_wdata[15:0];
            trace_unit_pkg::PREREQ_OFS:  prereq_reg <= reg_wdata[NCHAN*4-1:0];
            trace_unit_pkg::ACTION_OFS:  action_reg <= reg_wdata[NCHAN*4-1:0];
            trace_unit_pkg::BUF_SEL_OFS: sel_reg    <= reg_wdata[PTR_W-1:0];
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            trace_unit_pkg::CTRL_OFS:     reg_rdata <= 32'(ctrl_reg);
            trace_unit_pkg::WIN_LO_OFS:   reg_rdata <= win_lo_reg;
            trace_unit_pkg::WIN_HI_OFS:   reg_rdata <= win_hi_reg;
            trace_unit_pkg::QUAL_OFS:     reg_rdata <= 32'(qual_reg);
            trace_unit_pkg::PREREQ_OFS:   reg_rdata <= 32'(prereq_reg);
            trace_unit_pkg::ACTION_OFS:   reg_rdata <= 32'(action_reg);
            trace_unit_pkg::STATUS_OFS:
               reg_rdata <= {8'h00, lost_reg, 3'h0, stopped_reg, 4'(count_reg),
                             4'(done_reg), 3'h0, match_reg};
            trace_unit_pkg::BUF_SEL_OFS:  reg_rdata <= 32'(sel_reg);
            trace_unit_pkg::BUF_SRC_OFS:  reg_rdata <= src_mem[sel_reg];
            trace_unit_pkg::BUF_DST_OFS:  reg_rdata <= dst_mem[sel_reg];
            trace_unit_pkg::BUF_INFO_OFS: reg_rdata <= 32'(info_mem[sel_reg]);
            default:                      reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= 32'h0000_0000;
   end

   // Which channels arm others, and which hits count
   always_comb
   begin
      is_prereq = '0;
      counts    = '0;
      for (int i = 0; i < NCHAN; i++)
      begin
         if (chan_kind(prereq_reg, i) == trace_unit_pkg::PRE_CHAN)
            is_prereq[chan_src(prereq_reg, i)] = 1'b1;
         unique case (chan_kind(prereq_reg, i))
            trace_unit_pkg::PRE_CHAN:
               counts[i] = chan_hit[i] & done_reg[chan_src(prereq_reg, i)];
            trace_unit_pkg::PRE_MATCH:
               counts[i] = chan_hit[i] & match_reg;
            default:
               counts[i] = chan_hit[i];
         endcase
      end
   end

   // Break request from counting channels that arm nobody
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         break_req <= 1'b0;
      else
         break_req <= |(counts & ~is_prereq) & ~cpu_halted;
   end

   // Prerequisite-met states
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         done_reg <= '0;
      else if (cpu_halted || break_req)
         done_reg <= '0;
      else
         done_reg <= done_reg | counts;
   end

   // Shared match flag; highest channel's action wins
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         match_reg <= 1'b0;
      else if (cpu_halted || break_req)
         match_reg <= 1'b0;
      else
         for (int i = 0; i < NCHAN; i++)
            if (counts[i] && chan_kind(action_reg, i) == trace_unit_pkg::ACT_SET)
               match_reg <= 1'b1;
            else if (counts[i] && chan_kind(action_reg, i) == trace_unit_pkg::ACT_CLEAR)
               match_reg <= 1'b0;
   end

   // Record selection: software, then branch, then range access
   assign br_ok  = br_valid && ctrl_reg[trace_unit_pkg::CTRL_BRANCH] && !br_cond_zero
                   && br_dst != trace_unit_pkg::RESET_VEC;
   assign rng_ok = acc_valid && ctrl_reg[trace_unit_pkg::CTRL_RANGE]
                   && acc_addr >= win_lo_reg && acc_addr <= win_hi_reg
                   && (acc_write ? qual_reg[trace_unit_pkg::QUAL_WR]
                                 : qual_reg[trace_unit_pkg::QUAL_RD])
                   && (!qual_reg[trace_unit_pkg::QUAL_ASID_EN]
                       || acc_asid == qual_reg[trace_unit_pkg::QUAL_ASID_LSB +: 8])
                   && (!qual_reg[trace_unit_pkg::QUAL_CYC_EN]
                       || acc_cycle == qual_reg[trace_unit_pkg::QUAL_CYC_LSB +: 2]);
   always_comb
   begin
      rec_valid = ctrl_reg[trace_unit_pkg::CTRL_TRACE_EN];
      rec_src   = 32'h0000_0000;
      rec_dst   = 32'h0000_0000;
      rec_info  = 6'h00;
      if (sw_valid && ctrl_reg[trace_unit_pkg::CTRL_SOFT])
      begin
         rec_src  = sw_pc;
         rec_dst  = sw_reg;
         rec_info = {trace_unit_pkg::REC_SOFT, 4'h0};
      end
      else if (br_ok)
      begin
         rec_src  = br_exc_done ? br_src + trace_unit_pkg::INSN_STEP : br_src;
         rec_dst  = br_dst;
         rec_info = {trace_unit_pkg::REC_BRANCH, br_type, br_master};
      end
      else if (rng_ok)
      begin
         rec_src  = acc_addr;
         rec_info = {trace_unit_pkg::REC_RANGE, acc_cycle, acc_write, 1'b0};
      end
      else
         rec_valid = 1'b0;
   end

   // Capture qualifiers
   assign ext_on            = ctrl_reg[trace_unit_pkg::CTRL_EXT_EN];
   assign trace_port_select = ext_on;
   assign busy              = nib_reg != 5'd0;
   assign full              = count_reg == (PTR_W+1)'(trace_unit_pkg::BUF_DEPTH);
   assign cpu_stall = ext_on && !ctrl_reg[trace_unit_pkg::CTRL_REALTIME]
                      && busy && rec_valid;
   assign take_ext  = ext_on && rec_valid && !busy;
   assign take_int  = !ext_on && rec_valid && !stopped_reg;

   // Internal buffer storage, circular
   always_ff @(posedge mclk)
   begin
      if (take_int)
      begin
         src_mem[wr_ptr_reg]  <= rec_src;
         dst_mem[wr_ptr_reg]  <= rec_dst;
         info_mem[wr_ptr_reg] <= rec_info;
      end
   end

   // Buffer pointer, fill count and stop state
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr_reg  <= '0;
         count_reg   <= '0;
         stopped_reg <= 1'b0;
      end
      else if (reg_wr && reg_addr == trace_unit_pkg::CTRL_OFS)
      begin
         wr_ptr_reg  <= '0;
         count_reg   <= '0;
         stopped_reg <= 1'b0;
      end
      else if (take_int)
      begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (!full)
            count_reg <= count_reg + 1'b1;
         if (ctrl_reg[trace_unit_pkg::CTRL_STOP] &&
             count_reg == (PTR_W+1)'(trace_unit_pkg::BUF_DEPTH - 1))
            stopped_reg <= 1'b1;
      end
   end

   // External frame serialiser, low nibble first
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         frame_reg <= '0;
         nib_reg   <= 5'd0;
      end
      else if (take_ext)
      begin
         frame_reg <= {2'b00, rec_info, rec_dst, rec_src};
         nib_reg   <= 5'(trace_unit_pkg::FRAME_NIBS);
      end
      else if (busy)
      begin
         frame_reg <= frame_reg >> trace_unit_pkg::PORT_W;
         nib_reg   <= nib_reg - 5'd1;
      end
   end

   // Count of records dropped in realtime mode
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         lost_reg <= 8'h00;
      else if (ext_on && ctrl_reg[trace_unit_pkg::CTRL_REALTIME] && busy && rec_valid
               && lost_reg != 8'hFF)
         lost_reg <= lost_reg + 8'h01;
   end

   // Trace pins driven from the frame register
   assign trace_data_pins = busy ? frame_reg[trace_unit_pkg::PORT_W-1:0]
                                 : 4'h0;
   assign trace_valid     = busy;

   // Assertions
   sequence s_busy_hit;
      busy && rec_valid && ext_on;
   endsequence
   sequence s_break_seen;
      cpu_halted || break_req;
   endsequence

   a_prereq_arms: assert property (@(posedge mclk) disable iff (!rstn)
      (|(chan_hit & is_prereq) && !(|(counts & ~is_prereq))) |=> !break_req)
      else $error("prerequisite channel caused a break");
   a_chain_order: assert property (@(posedge mclk) disable iff (!rstn)
      counts[0] && chan_kind(prereq_reg, 0) == trace_unit_pkg::PRE_CHAN
      |-> done_reg[chan_src(prereq_reg, 0)])
      else $error("channel counted before its prerequisite");
   a_match_gate: assert property (@(posedge mclk) disable iff (!rstn)
      counts[0] && chan_kind(prereq_reg, 0) == trace_unit_pkg::PRE_MATCH |-> match_reg)
      else $error("channel counted without match flag");
   a_break_clear: assert property (@(posedge mclk) disable iff (!rstn)
      s_break_seen |=> !match_reg && done_reg == '0)
      else $error("break left sequencer state");
   a_stall_mode: assert property (@(posedge mclk) disable iff (!rstn)
      s_busy_hit ##0 !ctrl_reg[trace_unit_pkg::CTRL_REALTIME] |-> cpu_stall)
      else $error("no stall in non-realtime mode");
   a_realtime_run: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl_reg[trace_unit_pkg::CTRL_REALTIME] |-> !cpu_stall)
      else $error("stall in realtime mode");
   a_frame_len: assert property (@(posedge mclk) disable iff (!rstn)
      take_ext |=> trace_valid [*8] ##1 trace_valid [*8] ##1 trace_valid [*2]
      ##1 !trace_valid)
      else $error("frame not eighteen nibbles");
   a_stop_full: assert property (@(posedge mclk) disable iff (!rstn)
      stopped_reg && !reg_wr |=> $stable(wr_ptr_reg))
      else $error("capture after stop on full");
   a_no_reset_jump: assert property (@(posedge mclk) disable iff (!rstn)
      br_valid && br_dst == trace_unit_pkg::RESET_VEC && !sw_valid && !rng_ok
      |-> !rec_valid)
      else $error("reset jump was recorded");
   a_count_cap: assert property (@(posedge mclk) disable iff (!rstn)
      count_reg <= (PTR_W+1)'(trace_unit_pkg::BUF_DEPTH))
      else $error("buffer count beyond depth");
endmodule : seq_break_trace

// >>> trace_probe.sv
// External probe model that collects frames from the trace data port
`timescale 1ns/10ps
module trace_probe (
   // Clock
   input  wire logic                                 mclk,
   // Trace port
   input  wire logic [trace_unit_pkg::PORT_W-1:0]    trace_data_pins,
   input  wire logic                                 trace_valid,
   input  wire logic                                 trace_port_select,
   // Last frame and frame count
   output logic      [trace_unit_pkg::FRAME_W-1:0]   frame,
   output int                                        frames
);
   logic [trace_unit_pkg::FRAME_W-1:0] acc = '0;
   int                                 nib = 0;
   int                                 nfr = 0;
   assign frames = nfr;
   // Gather 18 nibbles a frame, low nibble first, only on trace pins
   always @(posedge mclk)
   begin
      if (trace_valid === 1'b1 && trace_port_select === 1'b1)
      begin
         acc[nib*4 +: 4] = trace_data_pins;
         if (nib == trace_unit_pkg::FRAME_NIBS - 1)
         begin
            frame <= acc;
            nfr <= nfr + 1;
            nib = 0;
         end
         else
            nib = nib + 1;
      end
   end
endmodule : trace_probe

// >>> seq_break_trace_tb_top.sv
// Self-checking testbench for the break sequencer and trace unit
`timescale 1ns/10ps
module seq_break_trace_tb_top;
   logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, cpu_halted = 0;
   logic [7:0] reg_addr = 0, acc_asid = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, br_src = 0, br_dst = 0;
   logic [31:0] acc_addr = 0, sw_pc = 0, sw_reg = 0, seed = 32'h59CF;
   logic [3:0] chan_hit = 0, trace_data_pins;
   logic [1:0] br_type = 0, br_master = 0, acc_cycle = 0;
   logic br_valid = 0, br_cond_zero = 0, br_exc_done = 0, acc_valid = 0;
   logic acc_write = 0, sw_valid = 0, break_req, cpu_stall, trace_valid;
   logic trace_port_select;
   logic [71:0] frame;
   int frames, fails = 0, checks = 0, cyc = 0, cnt = 0;
   logic [31:0] esrc [8], edst [8];
   logic [5:0] einfo [8], emsk [8];
   bit stp, stall_seen;
   seq_break_trace dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .chan_hit(chan_hit), .cpu_halted(cpu_halted), .break_req(break_req),
      .br_valid(br_valid), .br_src(br_src), .br_dst(br_dst), .br_type(br_type),
      .br_master(br_master), .br_cond_zero(br_cond_zero), .br_exc_done(br_exc_done),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
      .acc_asid(acc_asid), .acc_cycle(acc_cycle), .sw_valid(sw_valid), .sw_pc(sw_pc),
      .sw_reg(sw_reg), .cpu_stall(cpu_stall), .trace_data_pins(trace_data_pins),
      .trace_valid(trace_valid), .trace_port_select(trace_port_select));
   trace_probe probe (.mclk(mclk), .trace_data_pins(trace_data_pins),
      .trace_valid(trace_valid), .trace_port_select(trace_port_select),
      .frame(frame), .frames(frames));
   // Clock and hang guard
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         stop_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   // Branches that leave no record
   function automatic bit kept(input logic [31:0] d, input logic cz);
      return !(cz || d == trace_unit_pkg::RESET_VEC);
   endfunction : kept
   // Address recorded for a branch, stepped past a completed exception
   function automatic logic [31:0] rsrc(input logic [31:0] s, input logic ex);
      return ex ? s + trace_unit_pkg::INSN_STEP : s;
   endfunction : rsrc
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Register bus cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 0;
      @(negedge mclk);
      d = reg_rdata;
      @(posedge mclk);
   endtask : rd
   // One cycle of channel hits; halt the CPU if a break follows
   task automatic hit(input logic [3:0] m, output bit b);
      chan_hit <= m;
      @(posedge mclk);
      chan_hit <= 0;
      b = 0;
      repeat (3)
      begin
         @(negedge mclk);
         if (break_req === 1'b1)
            b = 1;
      end
      @(posedge mclk);
      cpu_halted <= b;
      repeat (2) @(posedge mclk);
      cpu_halted <= 0;
      @(posedge mclk);
   endtask : hit
   // Branch event held while the CPU is stalled
   task automatic br(input logic [31:0] s, d, input logic cz, ex, output logic [5:0] inf);
      logic [31:0] t;
      bit st;
      t = rnd();
      br_valid <= 1;
      br_src <= s;
      br_dst <= d;
      br_type <= t[1:0];
      br_master <= t[3:2];
      br_cond_zero <= cz;
      br_exc_done <= ex;
      inf = {2'b00, t[1:0], t[3:2]};
      do
      begin
         @(negedge mclk);
         st = (cpu_stall === 1'b1);
         if (st)
            stall_seen = 1;
         @(posedge mclk);
      end while (st);
      br_valid <= 0;
      @(posedge mclk);
   endtask : br
   // Expected record into the bench's copy of the buffer
   task automatic put(input logic [31:0] s, d, input logic [5:0] inf, msk);
      if (!stp || cnt < 8)
      begin
         esrc[cnt % 8] = s;
         edst[cnt % 8] = d;
         einfo[cnt % 8] = inf & msk;
         emsk[cnt % 8] = msk;
      end
      cnt++;
   endtask : put
   task automatic chkbuf();
      logic [31:0] v;
      rd(trace_unit_pkg::STATUS_OFS, v);
      chk("count", 32'(cnt > 8 ? 8 : cnt), 32'(v[11:8]));
      chk("stopped", 32'(stp && cnt >= 8), 32'(v[12]));
      for (int s = 0; s < (cnt > 8 ? 8 : cnt); s++)
      begin
         wr(trace_unit_pkg::BUF_SEL_OFS, 32'(s));
         rd(trace_unit_pkg::BUF_SRC_OFS, v);
         chk("src", esrc[s], v);
         rd(trace_unit_pkg::BUF_DST_OFS, v);
         if (einfo[s][5:4] !== 2'b01)
            chk("dst", edst[s], v);
         rd(trace_unit_pkg::BUF_INFO_OFS, v);
         chk("info", 32'(einfo[s]), 32'(v[5:0] & emsk[s]));
      end
   endtask : chkbuf
   // Twelve branches, two of them not recordable
   task automatic brun(input bit stop);
      logic [31:0] s, d;
      logic [5:0] inf;
      stp = stop;
      cnt = 0;
      wr(trace_unit_pkg::CTRL_OFS, stop ? 32'h29 : 32'h21);
      for (int i = 0; i < 12; i++)
      begin
         s = rnd();
         d = (i == 5) ? trace_unit_pkg::RESET_VEC : rnd();
         br(s, d, i == 3, i == 7, inf);
         if (kept(d, i == 3))
            put(rsrc(s, i == 7), d, inf, 6'h3F);
      end
      chkbuf();
   endtask : brun
   initial
   begin
      logic [31:0] v, a, s1, d1, s2, d2;
      logic [5:0] i1, i2;
      bit b;
      int f0;
      repeat (16) @(posedge mclk);
      rstn <= 1;
      @(posedge mclk);
      rd(trace_unit_pkg::CTRL_OFS, v);
      chk("ctrl", 32'(trace_unit_pkg::CTRL_RESET), v);
      wr(trace_unit_pkg::CTRL_OFS, 32'h10);
      rd(trace_unit_pkg::CTRL_OFS, v);
      chk("wide", 32'h0, v);
      rd(8'hFC, v);
      chk("unmapped", 32'h0, v);
      // Chain: channel 1 arms channel 0 and sets match; channel 3 needs match
      wr(trace_unit_pkg::PREREQ_OFS, 32'h2005);
      wr(trace_unit_pkg::ACTION_OFS, 32'h10);
      hit(4'h8, b);
      chk("brk ch3 nomatch", 0, 32'(b));
      hit(4'h1, b);
      chk("brk ch0 unarmed", 0, 32'(b));
      hit(4'h2, b);
      chk("brk prereq", 0, 32'(b));
      rd(trace_unit_pkg::STATUS_OFS, v);
      chk("match done", 32'h21, 32'(v[7:0]));
      hit(4'h8, b);
      chk("brk ch3 match", 1, 32'(b));
      rd(trace_unit_pkg::STATUS_OFS, v);
      chk("after break", 32'h0, 32'(v[7:0]));
      hit(4'h1, b);
      chk("brk rearm", 0, 32'(b));
      brun(0);
      brun(1);
      // Range window with write and address space qualifiers
      stp = 0;
      cnt = 0;
      wr(trace_unit_pkg::CTRL_OFS, 32'h41);
      wr(trace_unit_pkg::WIN_LO_OFS, 32'h1000);
      wr(trace_unit_pkg::WIN_HI_OFS, 32'h1FFF);
      wr(trace_unit_pkg::QUAL_OFS, 32'h5A06);
      for (int i = 0; i < 14; i++)
      begin
         v = rnd();
         a = (i < 3) ? 32'h1000 + 32'(i) * 32'hFFF : 32'(v[13:0]);
         acc_valid <= 1;
         acc_addr <= a;
         acc_write <= v[14] | (i < 3);
         acc_asid <= (v[15] && i >= 3) ? 8'h5B : 8'h5A;
         acc_cycle <= v[17:16];
         @(posedge mclk);
         acc_valid <= 0;
         @(posedge mclk);
         if (a <= 32'h1FFF && a >= 32'h1000 && (v[14] | (i < 3)) && !(v[15] && i >= 3))
            put(a, 0, {2'b01, v[17:16], 2'b10}, 6'h3E);
      end
      chkbuf();
      // Software trace instruction
      cnt = 0;
      wr(trace_unit_pkg::CTRL_OFS, 32'h81);
      repeat (3)
      begin
         sw_valid <= 1;
         sw_pc <= rnd();
         sw_reg <= rnd();
         @(posedge mclk);
         sw_valid <= 0;
         put(sw_pc, sw_reg, 6'h20, 6'h30);
         @(posedge mclk);
      end
      chkbuf();
      // External port, stalling mode, second branch while busy
      wr(trace_unit_pkg::CTRL_OFS, 32'h23);
      stall_seen = 0;
      s1 = rnd();
      d1 = rnd();
      s2 = rnd();
      d2 = rnd();
      br(s1, d1, 0, 0, i1);
      br(s2, d2, 0, 0, i2);
      for (int k = 0; k < 100 && frames < 2; k++) @(posedge mclk);
      chk("frames", 2, 32'(frames));
      chk("frame hi", {26'h0, i2}, frame[71:64]);
      chk("frame src", s2, frame[31:0]);
      chk("frame dst", d2, frame[63:32]);
      chk("pin select", 1, 32'(trace_port_select));
      chk("stall", 1, 32'(stall_seen));
      // Realtime mode drops the second branch instead of stalling
      wr(trace_unit_pkg::CTRL_OFS, 32'h27);
      stall_seen = 0;
      f0 = frames;
      br(s1, d1, 0, 0, i1);
      br(s2, d2, 0, 0, i2);
      repeat (60) @(posedge mclk);
      chk("rt stall", 0, 32'(stall_seen));
      chk("rt frames", 1, 32'(frames - f0));
      chk("rt src", s1, frame[31:0]);
      rd(trace_unit_pkg::STATUS_OFS, v);
      chk("lost", 1, 32'(v[23:16]));
      stop_test();
   end
endmodule : seq_break_trace_tb_top
